// ==== hw/emp_pin_groups.sv ====
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "emp_map.svh"

module emp_pin_groups
  import emp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins: 0-6 high address, 7-9 chip selects, 10-11 strobes
  input  wire logic [11:0] pin_in,
  output logic [11:0]      pin_out,
  output logic [11:0]      pin_oe,
  // Memory interface side
  input  wire logic [6:0]  mem_addr_hi,
  input  wire logic        chip_select_zero,
  input  wire logic        chip_select_three,
  input  wire logic        chip_select_four,
  input  wire logic        mem_write_strobe,
  input  wire logic        mem_read_strobe,
  output logic             mem_wait_request,
  // Per-group pad settings, index 0 AH, 1 CS, 2 CT
  output logic [2:0]       grp_drive_strength,
  output logic [2:0]       grp_drive_enable,
  output logic [2:0]       grp_input_char,
  output logic [2:0]       grp_input_level
);

  localparam int NG = `EMP_NUM_GRP;
  localparam int NK = `EMP_NUM_KIND;
  localparam int NP = `EMP_NUM_PINS;
  localparam int PIN_GRP [NP] = `EMP_PIN_GRP;
  localparam int PIN_BIT [NP] = `EMP_PIN_BIT;

  localparam logic [31:0] IDX [NG][NK] = '{
    '{`EMP_IDX_AH_OUT, `EMP_IDX_AH_DIR, `EMP_IDX_AH_FSEL,
      `EMP_IDX_AH_DS, `EMP_IDX_AH_DSE, `EMP_IDX_AH_ICC,
      `EMP_IDX_AH_ILC, `EMP_IDX_AH_PRB, `EMP_IDX_AH_RDC},
    '{`EMP_IDX_CS_OUT, `EMP_IDX_CS_DIR, `EMP_IDX_CS_FSEL,
      `EMP_IDX_CS_DS, `EMP_IDX_CS_DSE, `EMP_IDX_CS_ICC,
      `EMP_IDX_CS_ILC, `EMP_IDX_CS_PRB, `EMP_IDX_CS_RDC},
    '{`EMP_IDX_CT_OUT, `EMP_IDX_CT_DIR, `EMP_IDX_CT_FSEL,
      `EMP_IDX_CT_DS, `EMP_IDX_CT_DSE, `EMP_IDX_CT_ICC,
      `EMP_IDX_CT_ILC, `EMP_IDX_CT_PRB, `EMP_IDX_CT_RDC}
  };

  // Bits that exist in a register of group g, kind k
  function automatic emp_byte_t reg_mask(input int g, input int k);
    emp_byte_t m;
    m = `EMP_MASK_ONE;
    if (k == `EMP_K_OUT || k == `EMP_K_DIR || k == `EMP_K_FSEL ||
        k == `EMP_K_PRB) begin
      if (g == `EMP_G_AH)
        m = `EMP_MASK_AH;
      else if (g == `EMP_G_CS)
        m = `EMP_MASK_CS;
      else
        m = `EMP_MASK_CT;
    end
    return m;
  endfunction

  function automatic emp_byte_t reg_reset(input int g, input int k);
    emp_byte_t v;
    v = `EMP_RST_ZERO;
    if (k == `EMP_K_DIR || k == `EMP_K_ICC)
      v = `EMP_RST_ONES;
    else if (k == `EMP_K_ILC)
      v = `EMP_RST_LVL;
    return v & reg_mask(g, k);
  endfunction

  emp_byte_t   cfg_q [NG][NK];
  emp_chan_t   wr_st_q;
  emp_chan_t   rd_st_q;
  logic [1:0]  bresp_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [NP-1:0] pin_out_q;
  logic [NP-1:0] pin_oe_q;
  logic        wait_q;
  logic [NP-1:0] mem_fn;
  emp_byte_t   grp_in [NG];
  emp_byte_t   grp_drv [NG];
  logic        wr_take;
  logic        rd_take;
  logic        wr_hit;
  logic        rd_hit;
  int          wr_g;
  int          wr_k;
  int          rd_g;
  int          rd_k;
  emp_byte_t   rd_val;

  // Memory function signals in pin order
  assign mem_fn = {mem_read_strobe, mem_write_strobe,
                   chip_select_four, chip_select_three,
                   chip_select_zero,
                   mem_addr_hi};

  // Write: address and data are taken together, one write in flight
  assign wr_take       = s_axi_awvalid & s_axi_wvalid &
                         (wr_st_q == EMP_CH_IDLE);
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = (wr_st_q == EMP_CH_RESP);
  assign s_axi_bresp   = bresp_q;
  assign rd_take       = s_axi_arvalid & (rd_st_q == EMP_CH_IDLE);
  assign s_axi_arready = (rd_st_q == EMP_CH_IDLE);
  assign s_axi_rvalid  = (rd_st_q == EMP_CH_RESP);
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Upper index bits fall off the 32-bit byte address
  always_comb begin
    wr_hit = 1'b0;
    wr_g   = 0;
    wr_k   = 0;
    rd_hit = 1'b0;
    rd_g   = 0;
    rd_k   = 0;
    for (int g = 0; g < NG; g++) begin
      for (int k = 0; k < NK; k++) begin
        if (s_axi_awaddr[31:2] == IDX[g][k][29:0]) begin
          wr_hit = 1'b1;
          wr_g   = g;
          wr_k   = k;
        end
        if (s_axi_araddr[31:2] == IDX[g][k][29:0]) begin
          rd_hit = 1'b1;
          rd_g   = g;
          rd_k   = k;
        end
      end
    end
  end

  // Gather pin levels and driven levels per group
  always_comb begin
    for (int g = 0; g < NG; g++) begin
      grp_in[g]  = `EMP_RST_ZERO;
      grp_drv[g] = `EMP_RST_ZERO;
    end
    for (int p = 0; p < NP; p++) begin
      grp_in[PIN_GRP[p]][PIN_BIT[p]]  = pin_in[p];
      grp_drv[PIN_GRP[p]][PIN_BIT[p]] = pin_out_q[p];
    end
  end

  // Readback source chosen once per group
  always_comb begin
    rd_val = cfg_q[rd_g][rd_k];
    if (rd_k == `EMP_K_PRB) begin
      if (cfg_q[rd_g][`EMP_K_RDC][`EMP_READ_SRC_BIT])
        rd_val = grp_drv[rd_g];
      else
        rd_val = grp_in[rd_g];
      rd_val = rd_val & reg_mask(rd_g, rd_k);
    end
    if (!rd_hit)
      rd_val = `EMP_RST_ZERO;
  end

  // Byte lane 0 carries the whole register; a single-bit change is a
  // read-modify-write of that byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int g = 0; g < NG; g++) begin
        for (int k = 0; k < NK; k++) begin
          cfg_q[g][k] <= reg_reset(g, k);
        end
      end
    end else if (wr_take && wr_hit && s_axi_wstrb[0] &&
                 wr_k != `EMP_K_PRB) begin
      cfg_q[wr_g][wr_k] <= s_axi_wdata[7:0] &
                           reg_mask(wr_g, wr_k);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_st_q <= EMP_CH_IDLE;
      bresp_q <= `EMP_RESP_OKAY;
    end else begin
      unique case (wr_st_q)
        EMP_CH_IDLE: begin
          if (wr_take) begin
            wr_st_q <= EMP_CH_RESP;
            bresp_q <= wr_hit ? `EMP_RESP_OKAY : `EMP_RESP_SLVERR;
          end
        end
        EMP_CH_RESP: begin
          if (s_axi_bready)
            wr_st_q <= EMP_CH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_st_q <= EMP_CH_IDLE;
      rresp_q <= `EMP_RESP_OKAY;
      rdata_q <= {`EMP_RDATA_PAD, `EMP_RST_ZERO};
    end else begin
      unique case (rd_st_q)
        EMP_CH_IDLE: begin
          if (rd_take) begin
            rd_st_q <= EMP_CH_RESP;
            rresp_q <= rd_hit ? `EMP_RESP_OKAY : `EMP_RESP_SLVERR;
            rdata_q <= {`EMP_RDATA_PAD, rd_val};
          end
        end
        EMP_CH_RESP: begin
          if (s_axi_rready)
            rd_st_q <= EMP_CH_IDLE;
        end
      endcase
    end
  end

  // Registered pads: one cycle of latency from memory signals to pins,
  // traded for glitch-free outputs
  for (genvar p = 0; p < NP; p++) begin : g_pin
    localparam int G = PIN_GRP[p];
    localparam int B = PIN_BIT[p];
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pin_out_q[p] <= 1'b0;
        pin_oe_q[p]  <= 1'b0;
      end else begin
        pin_oe_q[p] <= ~cfg_q[G][`EMP_K_DIR][B];
        if (cfg_q[G][`EMP_K_FSEL][B])
          pin_out_q[p] <= mem_fn[p];
        else
          pin_out_q[p] <= cfg_q[G][`EMP_K_OUT][B];
      end
    end
  end

  // Wait input exists only on chip-select bit 4 in memory input mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      wait_q <= 1'b0;
    else
      wait_q <= cfg_q[`EMP_G_CS][`EMP_K_FSEL][PIN_BIT[`EMP_WAIT_PIN]] &
                cfg_q[`EMP_G_CS][`EMP_K_DIR][PIN_BIT[`EMP_WAIT_PIN]] &
                pin_in[`EMP_WAIT_PIN];
  end

  assign pin_out          = pin_out_q;
  assign pin_oe           = pin_oe_q;
  assign mem_wait_request = wait_q;

  for (genvar g = 0; g < NG; g++) begin : g_pad
    assign grp_drive_strength[g] = cfg_q[g][`EMP_K_DS][`EMP_PAD_CFG_BIT];
    assign grp_drive_enable[g]   = cfg_q[g][`EMP_K_DSE][`EMP_PAD_CFG_BIT];
    assign grp_input_char[g]     = cfg_q[g][`EMP_K_ICC][`EMP_PAD_CFG_BIT];
    assign grp_input_level[g]    = cfg_q[g][`EMP_K_ILC][`EMP_PAD_CFG_BIT];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_port_latch_drive: assert property (
    !cfg_q[0][`EMP_K_FSEL][0] && !cfg_q[0][`EMP_K_DIR][0]
    |=> pin_oe[0] && pin_out[0] == $past(cfg_q[0][`EMP_K_OUT][0]))
    else $error("port pin not driven from output latch");

  a_addr_line_drive: assert property (
    cfg_q[0][`EMP_K_FSEL][6] && !cfg_q[0][`EMP_K_DIR][6]
    |=> pin_oe[6] && pin_out[6] == $past(mem_addr_hi[6]))
    else $error("address line 22 not on its pin");

  a_chip_sel_map: assert property (
    cfg_q[1][`EMP_K_FSEL][3] && !cfg_q[1][`EMP_K_DIR][3]
    |=> pin_out[8] == $past(chip_select_three))
    else $error("chip select three not on its pin");

  a_read_strobe_map: assert property (
    cfg_q[2][`EMP_K_FSEL][4] && !cfg_q[2][`EMP_K_DIR][4]
    |=> pin_out[11] == $past(mem_read_strobe))
    else $error("read strobe not on its pin");

  a_input_no_drive: assert property (
    cfg_q[0][`EMP_K_DIR][2] |=> !pin_oe[2])
    else $error("pin driven while in input mode");

  a_wait_route: assert property (
    cfg_q[1][`EMP_K_FSEL][4] && cfg_q[1][`EMP_K_DIR][4]
    |=> mem_wait_request == $past(pin_in[9]))
    else $error("wait request not taken from pin");

  a_wait_quiet: assert property (
    !cfg_q[1][`EMP_K_FSEL][4] |=> !mem_wait_request)
    else $error("wait request outside memory input mode");

  a_unused_bits_zero: assert property (
    cfg_q[1][`EMP_K_DIR][2:1] == 2'b00 && cfg_q[2][`EMP_K_OUT][3:1] == 3'b000
    && cfg_q[0][`EMP_K_FSEL][7] == 1'b0)
    else $error("unimplemented register bit set");

  a_readback_source: assert property (
    rd_take && rd_hit && rd_k == `EMP_K_PRB && rd_g == 0 &&
    !cfg_q[0][`EMP_K_RDC][0]
    |=> s_axi_rdata[6:0] == $past(pin_in[6:0]))
    else $error("readback not from pin levels");

  a_write_resp: assert property (
    wr_take ##1 s_axi_bready |-> s_axi_bvalid ##1 !s_axi_bvalid)
    else $error("write answer not one cycle after take");

  // First cycle out of reset: no pad driven, no answer pending
  a_reset_idle: assert property (
    $past(nrst) == 1'b0
    |-> pin_oe == '0 && pin_out == '0 && !mem_wait_request &&
        !s_axi_bvalid && !s_axi_rvalid)
    else $error("pads or bus not idle after reset");

  a_write_strobe_map: assert property (
    cfg_q[2][`EMP_K_FSEL][0] && !cfg_q[2][`EMP_K_DIR][0]
    |=> pin_oe[10] && pin_out[10] == $past(mem_write_strobe))
    else $error("write strobe not on its pin");

  a_select_zero_map: assert property (
    cfg_q[1][`EMP_K_FSEL][0] && !cfg_q[1][`EMP_K_DIR][0]
    |=> pin_oe[7] && pin_out[7] == $past(chip_select_zero))
    else $error("chip select zero not on its pin");

  a_mem_input_quiet: assert property (
    cfg_q[2][`EMP_K_FSEL][4] && cfg_q[2][`EMP_K_DIR][4] |=> !pin_oe[11])
    else $error("read strobe pin driven in input mode");

  a_port_select_drive: assert property (
    !cfg_q[1][`EMP_K_FSEL][4] && !cfg_q[1][`EMP_K_DIR][4]
    |=> pin_oe[9] && pin_out[9] == $past(cfg_q[1][`EMP_K_OUT][4]))
    else $error("select pin not driven from output latch");

  // Driven readback shows the registered pad output, so a loaded pad cannot fool it
  a_readback_driven: assert property (
    rd_take && rd_hit && rd_k == `EMP_K_PRB && rd_g == `EMP_G_CS &&
    cfg_q[`EMP_G_CS][`EMP_K_RDC][`EMP_READ_SRC_BIT]
    |=> s_axi_rdata[0] == $past(pin_out[7]) &&
        s_axi_rdata[3] == $past(pin_out[8]) &&
        s_axi_rdata[4] == $past(pin_out[9]) &&
        s_axi_rdata[2:1] == 2'h0)
    else $error("readback not from driven levels");

  c_mem_addr_mode: cover property (
    cfg_q[0][`EMP_K_FSEL][0] && !cfg_q[0][`EMP_K_DIR][0]);
  c_wait_mode: cover property (mem_wait_request);
  c_bad_addr: cover property (s_axi_bvalid &&
    s_axi_bresp == `EMP_RESP_SLVERR);
  c_driven_readback: cover property (rd_take && rd_k == `EMP_K_PRB &&
    cfg_q[`EMP_G_CS][`EMP_K_RDC][`EMP_READ_SRC_BIT]);
  c_port_output: cover property (pin_oe[7] &&
    !cfg_q[`EMP_G_CS][`EMP_K_FSEL][0]);

endmodule // emp_pin_groups
`default_nettype wire

// ==== include/emp_map.svh ====
`ifndef EMP_MAP_SVH
`define EMP_MAP_SVH
// Behaviour
// - Function-select bit clear: the pin works as a general-purpose port pin.
// - Function-select bit set: the pin carries its memory interface signal.
// - Memory function, direction clear: the pin drives address, select or strobe.
// - Memory function, direction set: only chip-select bit 4 takes wait input.
// - After reset every pin is a port pin in input mode.
// - High-address group: seven pins, bit n carries address line 16 plus n.
// - Chip-select group: bits 0, 3, 4 output chip selects 0, 3, 4.
// - Strobe group: bit 0 outputs write strobe, bit 4 read strobe.
// - Read-source bit 0 governs every pin of its group together.
// - Each 8-bit register but the read-only pin readback takes whole-byte writes on byte lane 0; a single-bit change is a read-modify-write.

// Register indices; the bus byte address is four times the index
`define EMP_IDX_AH_OUT  32'hffff_f002
`define EMP_IDX_CS_OUT  32'hffff_f008
`define EMP_IDX_CT_OUT  32'hffff_f00a
`define EMP_IDX_AH_DIR  32'hffff_f022
`define EMP_IDX_CS_DIR  32'hffff_f028
`define EMP_IDX_CT_DIR  32'hffff_f02a
`define EMP_IDX_AH_FSEL 32'hffff_f042
`define EMP_IDX_CS_FSEL 32'hffff_f048
`define EMP_IDX_CT_FSEL 32'hffff_f04a
`define EMP_IDX_AH_DS   32'hffff_f242
`define EMP_IDX_CS_DS   32'hffff_f248
`define EMP_IDX_CT_DS   32'hffff_f24a
`define EMP_IDX_AH_DSE  32'hffff_f262
`define EMP_IDX_CS_DSE  32'hffff_f268
`define EMP_IDX_CT_DSE  32'hffff_f26a
`define EMP_IDX_AH_ICC  32'hffff_f282
`define EMP_IDX_CS_ICC  32'hffff_f288
`define EMP_IDX_CT_ICC  32'hffff_f28a
`define EMP_IDX_AH_ILC  32'hffff_f2a2
`define EMP_IDX_CS_ILC  32'hffff_f2a8
`define EMP_IDX_CT_ILC  32'hffff_f2aa
`define EMP_IDX_AH_PRB  32'hffff_f2c2
`define EMP_IDX_CS_PRB  32'hffff_f2c8
`define EMP_IDX_CT_PRB  32'hffff_f2ca
`define EMP_IDX_AH_RDC  32'hffff_f2e2
`define EMP_IDX_CS_RDC  32'hffff_f2e8
`define EMP_IDX_CT_RDC  32'hffff_f2ea

`define EMP_NUM_GRP  3
`define EMP_NUM_KIND 9
`define EMP_NUM_PINS 12
`define EMP_G_AH 0
`define EMP_G_CS 1
`define EMP_G_CT 2
`define EMP_K_OUT  0
`define EMP_K_DIR  1
`define EMP_K_FSEL 2
`define EMP_K_DS   3
`define EMP_K_DSE  4
`define EMP_K_ICC  5
`define EMP_K_ILC  6
`define EMP_K_PRB  7
`define EMP_K_RDC  8

`define EMP_MASK_AH  8'h7f
`define EMP_MASK_CS  8'h19
`define EMP_MASK_CT  8'h11
`define EMP_MASK_ONE 8'h01
`define EMP_RST_ZERO 8'h00
`define EMP_RST_ONES 8'hff
`define EMP_RST_LVL  8'h01
`define EMP_READ_SRC_BIT 0
`define EMP_PAD_CFG_BIT  0
`define EMP_WAIT_PIN 9
`define EMP_PIN_GRP '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 2, 2}
`define EMP_PIN_BIT '{0, 1, 2, 3, 4, 5, 6, 0, 3, 4, 0, 4}
`define EMP_RESP_OKAY   2'b00
`define EMP_RESP_SLVERR 2'b10
`define EMP_RDATA_PAD   24'h00_0000

`endif

// ==== include/emp_pkg.sv ====
package emp_pkg;
  typedef logic [7:0] emp_byte_t;
  typedef enum logic {EMP_CH_IDLE, EMP_CH_RESP} emp_chan_t;
endpackage

// ==== verif/emp_ext_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far side of the pads: memory devices plus board levels on released pins
module emp_ext_mem_model (
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  input  wire logic [11:0] ext_lvl,
  input  wire logic        wait_drive,
  input  wire logic        wait_req,
  output logic [11:0]      pin_in
);
  // Released pins show the board level (pin 9 shows wait_req while wait_drive is set), never the last driven value
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
    if (!pin_oe[9] && wait_drive) begin
      pin_in[9] = wait_req;
    end
  end
endmodule // emp_ext_mem_model

`default_nettype wire

// ==== verif/ext_mem_ctrl_pin_groups_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "emp_map.svh"

module ext_mem_ctrl_pin_groups_tb_top
  import emp_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mem_wait;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] pin_in, pin_out, pin_oe;
  logic [11:0] ext_lvl = '0;
  logic [6:0]  mem_addr_hi = '0;
  logic        chip_select_zero = 1'b0;
  logic        chip_select_three = 1'b0;
  logic        chip_select_four = 1'b0;
  logic        wr_stb = 1'b0, rd_stb = 1'b0;
  logic        wait_drive = 1'b0, wait_req = 1'b0;
  logic [2:0]  ds, dse, icc, ilc;
  int          miscompares = 0;
  int          checks_done = 0;
  logic [11:0] kb [9] = '{12'h000, 12'h020, 12'h040, 12'h240, 12'h260,
                          12'h280, 12'h2a0, 12'h2c0, 12'h2e0};
  emp_byte_t   go [3] = '{8'h02, 8'h08, 8'h0a};
  emp_byte_t   mk [3] = '{`EMP_MASK_AH, `EMP_MASK_CS, `EMP_MASK_CT};

  emp_pin_groups emp_pin_groups_i (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mem_addr_hi(mem_addr_hi),
    .chip_select_zero(chip_select_zero),
    .chip_select_three(chip_select_three),
    .chip_select_four(chip_select_four),
    .mem_write_strobe(wr_stb), .mem_read_strobe(rd_stb),
    .mem_wait_request(mem_wait),
    .grp_drive_strength(ds), .grp_drive_enable(dse),
    .grp_input_char(icc), .grp_input_level(ilc)
  );

  emp_ext_mem_model emp_ext_mem_model_i (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .wait_drive(wait_drive), .wait_req(wait_req), .pin_in(pin_in)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [11:0] e,
                         input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] idx(input int g, input int k);
    return 32'hffff_f000 + 32'(kb[k]) + 32'(go[g]);
  endfunction

  task automatic axi_wr(input logic [31:0] a, input emp_byte_t d,
                        input logic [3:0] s, input logic [1:0] er);
    awaddr <= a << 2;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    chk_reg("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    araddr <= a << 2;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    chk_reg("rdata", e, rdata);
    chk_reg("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // One byte per group: AH in [7:0], CS in [15:8], CT in [23:16]
  task automatic cfg(input int k, input logic [23:0] v);
    for (int g = 0; g < 3; g++) begin
      axi_wr(idx(g, k), v[8*g +: 8], 4'hf, `EMP_RESP_OKAY);
    end
  endtask

  task automatic rdg(input int k, input logic [23:0] v);
    for (int g = 0; g < 3; g++) begin
      axi_rd(idx(g, k), 32'(v[8*g +: 8]), `EMP_RESP_OKAY);
    end
  endtask

  // Pins follow a register write one edge after the take
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_pin("pin_oe", 12'h000, pin_oe);
    chk_pin("grp_cfg", 12'h03f, {ds, dse, icc, ilc});
    for (int g = 0; g < 3; g++) begin
      for (int k = 0; k < 9; k++) begin
        axi_rd(idx(g, k), (k == 1) ? 32'(mk[g]) : (k == 5 || k == 6) ?
               32'h0000_0001 : 32'h0000_0000, `EMP_RESP_OKAY);
      end
    end
    axi_wr(32'hffff_f003, 8'hff, 4'hf, `EMP_RESP_SLVERR);
    axi_rd(32'hffff_f003, 32'h0000_0000, `EMP_RESP_SLVERR);
    axi_wr(idx(0, 0), 8'hff, 4'h0, `EMP_RESP_OKAY);
    axi_rd(idx(0, 0), 32'h0000_0000, `EMP_RESP_OKAY);
    for (int g = 0; g < 3; g++) begin
      for (int k = 0; k < 9; k++) begin
        if (k != 7) begin
          axi_wr(idx(g, k), 8'hff, 4'hf, `EMP_RESP_OKAY);
          axi_rd(idx(g, k), (k < 3) ? 32'(mk[g]) : 32'h0000_0001,
                 `EMP_RESP_OKAY);
        end
      end
    end
    chk_pin("grp_cfg", 12'hfff, {ds, dse, icc, ilc});
    chk_pin("pin_oe", 12'h000, pin_oe);
    // Port inputs, readback of pad levels
    ext_lvl <= 12'ha5a;
    cfg(2, 24'h00_0000);
    cfg(8, 24'h00_0000);
    settle();
    chk_pin("pin_oe", 12'h000, pin_oe);
    rdg(7, 24'h10_105a);
    axi_wr(idx(0, 7), 8'h00, 4'hf, `EMP_RESP_OKAY);
    axi_rd(idx(0, 7), 32'h0000_005a, `EMP_RESP_OKAY);
    // Port outputs, readback of driven values
    cfg(1, 24'h00_0000);
    cfg(0, 24'h10_0955);
    cfg(8, 24'h01_0101);
    settle();
    chk_pin("pin_oe", 12'hfff, pin_oe);
    chk_pin("pin_out", 12'h9d5, pin_out);
    rdg(7, 24'h10_0955);
    // Memory interface outputs
    mem_addr_hi <= 7'h2b;
    chip_select_zero <= 1'b1;
    chip_select_four <= 1'b1;
    rd_stb <= 1'b1;
    cfg(2, 24'h11_197f);
    settle();
    chk_pin("pin_oe", 12'hfff, pin_oe);
    chk_pin("pin_out", 12'haab, pin_out);
    mem_addr_hi <= 7'h54;
    chip_select_zero <= 1'b0;
    chip_select_three <= 1'b1;
    chip_select_four <= 1'b0;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    settle();
    chk_pin("pin_out", 12'h554, pin_out);
    // Wait request through chip-select bit 4
    wait_drive <= 1'b1;
    wait_req <= 1'b1;
    axi_wr(idx(1, 1), 8'h10, 4'hf, `EMP_RESP_OKAY);
    settle();
    chk_pin("pin_oe", 12'hdff, pin_oe);
    chk_reg("mem_wait", 32'h0000_0001, 32'(mem_wait));
    wait_req <= 1'b0;
    settle();
    chk_reg("mem_wait", 32'h0000_0000, 32'(mem_wait));
    wait_req <= 1'b1;
    axi_wr(idx(1, 2), 8'h00, 4'hf, `EMP_RESP_OKAY);
    settle();
    chk_reg("mem_wait", 32'h0000_0000, 32'(mem_wait));
    chk_pin("pin_oe", 12'hdff, pin_oe);
    print_verdict();
  end

  // Full run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule // ext_mem_ctrl_pin_groups_tb_top

`default_nettype wire
